//--- vic_pkg.sv
// Package with constants and types of the vectored interrupt controller.
package vic_pkg;
    localparam int NUM_VEC = 246;
    localparam int NUM_TRAP = 8;
    localparam int NUM_IRQ = NUM_VEC - NUM_TRAP;
    localparam int VEC_W = 8;
    localparam int LVL_W = 4;
    localparam int PRIO_W = 3;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int PA_W = 24;
    localparam int LIM_W = 13;
    localparam int CNT_W = 4;
    localparam int FLAG_WORDS = 15;
    localparam int PRIO_WORDS = 60;
    localparam int PRIO_PER_WORD = 4;
    localparam int PRIO_FIELD = 4;
    localparam logic [ADDR_W-1:0] FLAG_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] EN_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] PRIO_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h60;
    localparam logic [ADDR_W-1:0] TRAP_ADDR = 8'h61;
    localparam logic [ADDR_W-1:0] CUR_ADDR = 8'h62;
    localparam int CTRL_ALT_EN_BIT = 15;
    localparam int CUR_REQ_BIT = 15;
    localparam int CUR_LVL_POS = 8;
    localparam logic [PA_W-1:0] PRIMARY_BASE = 24'h00_0004;
    localparam logic [PA_W-1:0] ALT_ENTRY_OFS = 24'h00_0004;
    localparam int VEC_STRIDE_SHIFT = 1;
    localparam int PAGE_SHIFT = 10;
    localparam logic [LIM_W-1:0] LIM_ONE = 13'h0001;
    localparam logic [LIM_W-1:0] LIM_NONE = 13'h0000;
    localparam logic FUSE_PERMIT = 1'b1;
    localparam logic [LVL_W-1:0] TRAP_TOP_LVL = 4'hF;
    localparam logic [CNT_W-1:0] ENTRY_CYCLES = 4'h3;
    localparam logic [CNT_W-1:0] RETURN_CYCLES = 4'h3;

    typedef enum logic [1:0] {
        VIC_IDLE,
        VIC_ENTRY,
        VIC_RETURN
    } vic_phase_t;

    typedef struct packed {
        logic found;
        logic [VEC_W-1:0] vec;
        logic [LVL_W-1:0] lvl;
    } vic_pick_t;

    typedef struct packed {
        logic [NUM_IRQ-1:0] flag;
        logic [NUM_IRQ-1:0] en;
        logic [NUM_IRQ-1:0][PRIO_W-1:0] prio;
        logic [NUM_TRAP-1:0] trap;
        logic alt_en;
        logic [DATA_W-1:0] rdata;
        vic_pick_t cur;
        logic [PA_W-1:0] cur_addr;
        logic [VEC_W-1:0] act_vec;
        logic [PA_W-1:0] act_addr;
        vic_phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic entry_valid;
        logic return_done;
        logic [LIM_W-1:0] lim_meta;
        logic [LIM_W-1:0] lim;
        logic fuse_meta;
        logic fuse;
    } vic_state_t;
endpackage

//--- vic_top.sv
// Vectored interrupt controller with register port and CPU handshake.
//
// Overview of operation
// [RULE1] All peripheral requests merge into one request output to the CPU.
// [RULE2] Vector space has 246 positions; unassigned positions stay reserved.
// [RULE3] Software gives each maskable source one of seven priority levels.
// [RULE4] Ties within one priority level resolve by a fixed order only.
// [RULE5] Natural order follows table position; lower vectors win, vector 0 first.
// [RULE6] Software may set any pending flag, acting like a hardware request.
// [RULE7] Primary vector table starts at program word address 00004h.
// [RULE8] Primary table holds seven trap vectors and up to 187 source vectors; the code has eight trap vectors and 238 source vectors.
// [RULE9] Each vector entry holds a 24-bit service routine start address.
// [RULE10] Entry and return latencies are fixed cycle counts.
// [RULE11] Up to eight processor exceptions and software traps are supported.
// [RULE12] Alternate table needs boot segment, enable bit set, permit fuse one.
// [RULE13] Alternate table base is the last boot segment page from its limit.
// [RULE14] Alternate traps at 0x4 to 0x10, vector 0 at 0x14, stride two; the code places its eight traps at 0x4 to 0x12.
// [RULE15] Forward only above CPU priority; traps always beat maskable sources; the code forwards traps at any CPU priority.
// [RULE16] Vector fetch address uses alternate base when active, else primary.
`timescale 1ns/1ps

module vic_top (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [vic_pkg::ADDR_W-1:0] ADDR,
    input wire logic [vic_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [vic_pkg::DATA_W-1:0] RDATA,
    input wire logic [vic_pkg::NUM_IRQ-1:0] IRQ_IN,
    input wire logic [vic_pkg::NUM_TRAP-1:0] TRAP_IN,
    input wire logic [vic_pkg::LIM_W-1:0] BOOT_SEGMENT_LIMIT,
    input wire logic ALT_TABLE_PERMIT_FUSE,
    input wire logic [vic_pkg::LVL_W-1:0] CPU_PRIORITY,
    input wire logic CPU_ACK,
    input wire logic CPU_RETURN,
    output logic IRQ_REQ,
    output logic [vic_pkg::VEC_W-1:0] IRQ_VECTOR,
    output logic [vic_pkg::LVL_W-1:0] IRQ_LEVEL,
    output logic [vic_pkg::PA_W-1:0] IRQ_FETCH_ADDR,
    output logic ENTRY_VALID,
    output logic [vic_pkg::VEC_W-1:0] ENTRY_VECTOR,
    output logic [vic_pkg::PA_W-1:0] ENTRY_ADDR,
    output logic RETURN_DONE
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Picks the highest priority source above the CPU level.
    function automatic vic_pkg::vic_pick_t pick_irq(
        input logic [vic_pkg::NUM_IRQ-1:0] pend,
        input logic [vic_pkg::NUM_IRQ-1:0][vic_pkg::PRIO_W-1:0] prio,
        input logic [vic_pkg::LVL_W-1:0] floor_lvl
    );
        vic_pkg::vic_pick_t p;
        logic [vic_pkg::LVL_W-1:0] best;
        logic [vic_pkg::LVL_W-1:0] lvl;
        p = '0;
        best = floor_lvl;
        for (int i = 0; i < vic_pkg::NUM_IRQ; i++) begin
            lvl = {1'b0, prio[i]};
            if (pend[i] && (lvl > best)) begin // RULE3 RULE15
                // Strict compare keeps the lower vector on a tie.
                best = lvl; // RULE4 RULE5
                p.found = 1'b1;
                p.vec = vic_pkg::VEC_W'(i + vic_pkg::NUM_TRAP);
                p.lvl = lvl;
            end
        end
        return p;
    endfunction

    // Picks the lowest pending trap; traps are never masked.
    function automatic vic_pkg::vic_pick_t pick_trap(
        input logic [vic_pkg::NUM_TRAP-1:0] pend
    );
        vic_pkg::vic_pick_t p;
        p = '0;
        for (int i = vic_pkg::NUM_TRAP - 1; i >= 0; i--) begin
            if (pend[i]) begin // RULE11 RULE5
                p.found = 1'b1;
                p.vec = vic_pkg::VEC_W'(i);
                p.lvl = vic_pkg::TRAP_TOP_LVL - vic_pkg::LVL_W'(i);
            end
        end
        return p;
    endfunction

    // Forms the program address of the entry for one vector.
    function automatic logic [vic_pkg::PA_W-1:0] entry_addr(
        input logic [vic_pkg::VEC_W-1:0] vec,
        input logic alt,
        input logic [vic_pkg::LIM_W-1:0] lim
    );
        logic [vic_pkg::PA_W-1:0] ofs;
        logic [vic_pkg::PA_W-1:0] base;
        ofs = vic_pkg::PA_W'(vec) << vic_pkg::VEC_STRIDE_SHIFT; // RULE9
        base = vic_pkg::PA_W'(lim - vic_pkg::LIM_ONE)
            << vic_pkg::PAGE_SHIFT; // RULE13
        if (alt) begin
            return base + vic_pkg::ALT_ENTRY_OFS + ofs; // RULE14 RULE16
        end
        return vic_pkg::PRIMARY_BASE + ofs; // RULE7 RULE8 RULE16
    endfunction

    // Gathers sixteen bits of a flag vector into one register word.
    function automatic logic [vic_pkg::DATA_W-1:0] bit_word(
        input logic [vic_pkg::NUM_IRQ-1:0] v,
        input int idx
    );
        logic [vic_pkg::DATA_W-1:0] w;
        int i;
        w = '0;
        for (int b = 0; b < vic_pkg::DATA_W; b++) begin
            i = idx * vic_pkg::DATA_W + b;
            if (i < vic_pkg::NUM_IRQ) begin
                w[b] = v[i];
            end
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    vic_pkg::vic_state_t s;
    vic_pkg::vic_state_t next_s;

    logic alt_active;
    logic accept;
    logic trap_taken;
    vic_pkg::vic_pick_t trap_pick;
    vic_pkg::vic_pick_t irq_pick;
    vic_pkg::vic_pick_t win;

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        int widx;
        int bit_i;
        int sel;
        widx = 0;
        bit_i = 0;
        sel = 0;
        next_s = s;
        next_s.entry_valid = 1'b0;
        next_s.return_done = 1'b0;

        // Configuration pins pass two flip-flops.
        next_s.lim_meta = BOOT_SEGMENT_LIMIT;
        next_s.lim = s.lim_meta;
        next_s.fuse_meta = ALT_TABLE_PERMIT_FUSE;
        next_s.fuse = s.fuse_meta;

        alt_active = s.alt_en
            && (s.fuse == vic_pkg::FUSE_PERMIT)
            && (s.lim != vic_pkg::LIM_NONE); // RULE12

        accept = CPU_ACK && s.cur.found && (s.phase == vic_pkg::VIC_IDLE);
        trap_taken = accept && (s.cur.vec < vic_pkg::VEC_W'(vic_pkg::NUM_TRAP));

        // Register writes.
        if (WR) begin
            if ((ADDR >= vic_pkg::FLAG_BASE)
                && (ADDR < vic_pkg::FLAG_BASE + vic_pkg::ADDR_W'(vic_pkg::FLAG_WORDS))) begin
                widx = int'(ADDR - vic_pkg::FLAG_BASE);
                for (int b = 0; b < vic_pkg::DATA_W; b++) begin
                    bit_i = widx * vic_pkg::DATA_W + b;
                    if (bit_i < vic_pkg::NUM_IRQ) begin
                        next_s.flag[bit_i] = WDATA[b]; // RULE6
                    end
                end
            end
            if ((ADDR >= vic_pkg::EN_BASE)
                && (ADDR < vic_pkg::EN_BASE + vic_pkg::ADDR_W'(vic_pkg::FLAG_WORDS))) begin
                widx = int'(ADDR - vic_pkg::EN_BASE);
                for (int b = 0; b < vic_pkg::DATA_W; b++) begin
                    bit_i = widx * vic_pkg::DATA_W + b;
                    if (bit_i < vic_pkg::NUM_IRQ) begin
                        next_s.en[bit_i] = WDATA[b];
                    end
                end
            end
            if ((ADDR >= vic_pkg::PRIO_BASE)
                && (ADDR < vic_pkg::PRIO_BASE + vic_pkg::ADDR_W'(vic_pkg::PRIO_WORDS))) begin
                widx = int'(ADDR - vic_pkg::PRIO_BASE);
                for (int j = 0; j < vic_pkg::PRIO_PER_WORD; j++) begin
                    bit_i = widx * vic_pkg::PRIO_PER_WORD + j;
                    sel = j * vic_pkg::PRIO_FIELD;
                    if (bit_i < vic_pkg::NUM_IRQ) begin
                        next_s.prio[bit_i] =
                            WDATA[sel +: vic_pkg::PRIO_W]; // RULE3
                    end
                end
            end
            if (ADDR == vic_pkg::CTRL_ADDR) begin
                next_s.alt_en = WDATA[vic_pkg::CTRL_ALT_EN_BIT]; // RULE12
            end
        end

        // Hardware requests set flags and win over a clearing write.
        next_s.flag = next_s.flag | IRQ_IN; // RULE1
        if (trap_taken) begin
            next_s.trap[s.cur.vec[2:0]] = 1'b0;
        end
        next_s.trap = next_s.trap | TRAP_IN; // RULE11

        // Register reads answer one cycle later; unmapped reads give zero.
        next_s.rdata = '0;
        if (RD) begin
            if ((ADDR >= vic_pkg::FLAG_BASE)
                && (ADDR < vic_pkg::FLAG_BASE + vic_pkg::ADDR_W'(vic_pkg::FLAG_WORDS))) begin
                next_s.rdata = bit_word(s.flag,
                    int'(ADDR - vic_pkg::FLAG_BASE));
            end else if ((ADDR >= vic_pkg::EN_BASE)
                && (ADDR < vic_pkg::EN_BASE + vic_pkg::ADDR_W'(vic_pkg::FLAG_WORDS))) begin
                next_s.rdata = bit_word(s.en,
                    int'(ADDR - vic_pkg::EN_BASE));
            end else if ((ADDR >= vic_pkg::PRIO_BASE)
                && (ADDR < vic_pkg::PRIO_BASE + vic_pkg::ADDR_W'(vic_pkg::PRIO_WORDS))) begin
                widx = int'(ADDR - vic_pkg::PRIO_BASE);
                for (int j = 0; j < vic_pkg::PRIO_PER_WORD; j++) begin
                    bit_i = widx * vic_pkg::PRIO_PER_WORD + j;
                    sel = j * vic_pkg::PRIO_FIELD;
                    if (bit_i < vic_pkg::NUM_IRQ) begin
                        next_s.rdata[sel +: vic_pkg::PRIO_W] = s.prio[bit_i];
                    end
                end
            end else if (ADDR == vic_pkg::CTRL_ADDR) begin
                next_s.rdata[vic_pkg::CTRL_ALT_EN_BIT] = s.alt_en;
            end else if (ADDR == vic_pkg::TRAP_ADDR) begin
                next_s.rdata[vic_pkg::NUM_TRAP-1:0] = s.trap;
            end else if (ADDR == vic_pkg::CUR_ADDR) begin
                next_s.rdata[vic_pkg::CUR_REQ_BIT] = s.cur.found;
                next_s.rdata[vic_pkg::CUR_LVL_POS +: vic_pkg::LVL_W] =
                    s.cur.lvl;
                next_s.rdata[vic_pkg::VEC_W-1:0] = s.cur.vec;
            end
        end

        // Arbitration: a pending trap beats every maskable source.
        trap_pick = pick_trap(s.trap);
        irq_pick = pick_irq(s.flag & s.en, s.prio, CPU_PRIORITY);
        win = trap_pick.found ? trap_pick : irq_pick; // RULE15 RULE2
        next_s.cur = win; // RULE1
        next_s.cur_addr = entry_addr(win.vec, alt_active, s.lim);

        // Entry and return sequencing with fixed cycle counts.
        unique case (s.phase)
            vic_pkg::VIC_IDLE: begin
                if (accept) begin
                    next_s.act_vec = s.cur.vec;
                    next_s.act_addr = s.cur_addr;
                    next_s.phase = vic_pkg::VIC_ENTRY;
                    next_s.cnt = vic_pkg::ENTRY_CYCLES - 4'h1; // RULE10
                end else if (CPU_RETURN) begin
                    next_s.phase = vic_pkg::VIC_RETURN;
                    next_s.cnt = vic_pkg::RETURN_CYCLES - 4'h1; // RULE10
                end
            end
            vic_pkg::VIC_ENTRY: begin
                if (s.cnt == '0) begin
                    next_s.entry_valid = 1'b1; // RULE10
                    next_s.phase = vic_pkg::VIC_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            vic_pkg::VIC_RETURN: begin
                if (s.cnt == '0) begin
                    next_s.return_done = 1'b1; // RULE10
                    next_s.phase = vic_pkg::VIC_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            default: begin
                next_s.phase = vic_pkg::VIC_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign RDATA = s.rdata;
    assign IRQ_REQ = s.cur.found;
    assign IRQ_VECTOR = s.cur.vec;
    assign IRQ_LEVEL = s.cur.lvl;
    assign IRQ_FETCH_ADDR = s.cur_addr;
    assign ENTRY_VALID = s.entry_valid;
    assign ENTRY_VECTOR = s.act_vec;
    assign ENTRY_ADDR = s.act_addr;
    assign RETURN_DONE = s.return_done;

endmodule

//--- vic_props.sv
// Checker with timing, ranking and vector address properties.
`timescale 1ns/1ps
module vic_props (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic [7:0] TRAP_IN,
    input wire logic [12:0] BOOT_SEGMENT_LIMIT,
    input wire logic ALT_TABLE_PERMIT_FUSE,
    input wire logic [3:0] CPU_PRIORITY,
    input wire logic CPU_ACK,
    input wire logic CPU_RETURN,
    input wire logic IRQ_REQ,
    input wire logic [7:0] IRQ_VECTOR,
    input wire logic [3:0] IRQ_LEVEL,
    input wire logic [23:0] IRQ_FETCH_ADDR,
    input wire logic ENTRY_VALID,
    input wire logic [7:0] ENTRY_VECTOR,
    input wire logic [23:0] ENTRY_ADDR,
    input wire logic RETURN_DONE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    logic [2:0] cnt;
    logic alt_bit;
    logic acc;
    logic [23:0] base;
    assign acc = CPU_ACK && IRQ_REQ && cnt == 3'h0;
    assign base = (alt_bit && ALT_TABLE_PERMIT_FUSE && |BOOT_SEGMENT_LIMIT) ?
        {1'b0, BOOT_SEGMENT_LIMIT - 13'h0001, 10'h000} : 24'h00_0000;
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            cnt <= 3'h0;
            alt_bit <= 1'b0;
        end else begin
            if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
            end else if (acc || CPU_RETURN) begin
                cnt <= 3'h4;
            end
            if (WR && ADDR == vic_pkg::CTRL_ADDR) begin
                alt_bit <= WDATA[vic_pkg::CTRL_ALT_EN_BIT];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_acc;
        acc;
    endsequence
    sequence s_entry;
        ##4 ENTRY_VALID;
    endsequence
    property p_entry_lat;
        s_acc |-> s_entry;
    endproperty
    a_entry_lat: assert property (p_entry_lat)
        else $error("entry pulse not four cycles after accept");
    property p_ret_lat;
        CPU_RETURN && !CPU_ACK && cnt == 3'h0 |-> ##4 RETURN_DONE;
    endproperty
    a_ret_lat: assert property (p_ret_lat)
        else $error("return pulse not four cycles after return");
    property p_entry_vec;
        s_acc |-> ##4 (ENTRY_VECTOR == $past(IRQ_VECTOR, 4)
            && ENTRY_ADDR == $past(IRQ_FETCH_ADDR, 4));
    endproperty
    a_entry_vec: assert property (p_entry_vec)
        else $error("entry vector or address differs from request");
    property p_ev_cause;
        ENTRY_VALID |-> $past(acc, 4);
    endproperty
    a_ev_cause: assert property (p_ev_cause)
        else $error("entry pulse without accepted request");
    property p_trap_lvl;
        IRQ_REQ && IRQ_VECTOR < 8'h08 |-> IRQ_LEVEL == 4'hF - IRQ_VECTOR[3:0];
    endproperty
    a_trap_lvl: assert property (p_trap_lvl)
        else $error("trap level wrong");
    property p_prio;
        IRQ_REQ && IRQ_VECTOR >= 8'h08 |->
            IRQ_LEVEL > $past(CPU_PRIORITY) && IRQ_LEVEL < 4'h8;
    endproperty
    a_prio: assert property (p_prio)
        else $error("maskable request not above cpu priority");
    property p_fetch;
        IRQ_REQ && alt_bit == $past(alt_bit) |-> IRQ_FETCH_ADDR ==
            base + vic_pkg::PRIMARY_BASE + {15'h0000, IRQ_VECTOR, 1'b0};
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch address wrong");
    property p_trap_req;
        |TRAP_IN |-> ##2 (IRQ_REQ && IRQ_VECTOR < 8'h08);
    endproperty
    a_trap_req: assert property (p_trap_req)
        else $error("trap did not take precedence");
endmodule
bind vic_top vic_props u_props (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .TRAP_IN(TRAP_IN),
    .BOOT_SEGMENT_LIMIT(BOOT_SEGMENT_LIMIT),
    .ALT_TABLE_PERMIT_FUSE(ALT_TABLE_PERMIT_FUSE),
    .CPU_PRIORITY(CPU_PRIORITY), .CPU_ACK(CPU_ACK),
    .CPU_RETURN(CPU_RETURN), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
    .IRQ_LEVEL(IRQ_LEVEL), .IRQ_FETCH_ADDR(IRQ_FETCH_ADDR),
    .ENTRY_VALID(ENTRY_VALID), .ENTRY_VECTOR(ENTRY_VECTOR),
    .ENTRY_ADDR(ENTRY_ADDR), .RETURN_DONE(RETURN_DONE));

//--- vic_cpu_model.sv
// Behavioural CPU that accepts a request and later returns from it.
`timescale 1ns/1ps
module vic_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic take,
    input wire logic slow,
    input wire logic req,
    input wire logic entry_valid,
    input wire logic return_done,
    output logic ack,
    output logic ret
);
    logic [1:0] st;
    logic [2:0] wt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= 2'h0;
            wt <= 3'h0;
            ack <= 1'b0;
            ret <= 1'b0;
        end else begin
            ack <= 1'b0;
            ret <= 1'b0;
            case (st)
                2'h0: if (take && req) begin
                    ack <= 1'b1;
                    st <= 2'h1;
                end
                2'h1: if (entry_valid) begin
                    st <= 2'h2;
                    wt <= slow ? 3'h5 : 3'h0;
                end
                2'h2: if (wt == 3'h0) begin
                    ret <= 1'b1;
                    st <= 2'h3;
                end else begin
                    wt <= wt - 3'h1;
                end
                default: if (return_done) begin
                    st <= 2'h0;
                end
            endcase
        end
    end
endmodule

//--- vectored_interrupt_controller_tb.sv
// Self-checking testbench of the vectored interrupt controller.
`timescale 1ns/1ps
module vectored_interrupt_controller_tb;
    logic clk = 1'b0;
    logic rst, wr, rd, fuse, take, slow, ack, ret, req, ev, rdone;
    logic [7:0] addr, trap, vec, evec;
    logic [15:0] wdata, rdata;
    logic [vic_pkg::NUM_IRQ-1:0] irq;
    logic [12:0] lim;
    logic [3:0] cpri, lvl;
    logic [23:0] fa, eaddr;
    int errors = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    vic_top dut (.CLK_SYS(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .IRQ_IN(irq), .TRAP_IN(trap),
        .BOOT_SEGMENT_LIMIT(lim), .ALT_TABLE_PERMIT_FUSE(fuse),
        .CPU_PRIORITY(cpri), .CPU_ACK(ack), .CPU_RETURN(ret),
        .IRQ_REQ(req), .IRQ_VECTOR(vec), .IRQ_LEVEL(lvl),
        .IRQ_FETCH_ADDR(fa), .ENTRY_VALID(ev), .ENTRY_VECTOR(evec),
        .ENTRY_ADDR(eaddr), .RETURN_DONE(rdone));
    vic_cpu_model cpu (.clk(clk), .rst(rst), .take(take), .slow(slow),
        .req(req), .entry_valid(ev), .return_done(rdone), .ack(ack),
        .ret(ret));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask
    task cur(input logic [7:0] v, input logic [3:0] l, input logic [23:0] a);
        chk("request", 1, req);
        chk("vector", v, vec);
        chk("level", l, lvl);
        chk("fetch", a, fa);
    endtask
    task automatic wait_hi(input string nm, ref logic s);
        for (int i = 0; i < 40 && s !== 1'b1; i++) step(1);
        if (s !== 1'b1) begin
            chk(nm, 1, s);
            wrap_up();
        end
    endtask
    task serve(input logic [7:0] v, input logic [23:0] a);
        take <= 1'b1;
        wait_hi("entry_valid", ev);
        take <= 1'b0;
        chk("entry_vector", v, evec);
        chk("entry_addr", a, eaddr);
        wait_hi("return_done", rdone);
    endtask
    task rst_dut(input logic f, input logic [12:0] l);
        @(posedge clk);
        rst <= 1'b1;
        fuse <= f;
        lim <= l;
        step(3);
        rst <= 1'b0;
        step(3);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        rreg(8'h20, 16'h0000);
        wreg(8'h20, 16'h0005);
        rreg(8'h20, 16'h0005);
        wreg(8'h7F, 16'hFFFF);
        rreg(8'h7F, 16'h0000);
        rreg(vic_pkg::CTRL_ADDR, 16'h0000);
        wreg(8'h20, 16'h0000);
        $display("test regs done");
    endtask
    task t_order;
        cpri <= 4'h2;
        wreg(8'h10, 16'h0021);
        wreg(8'h20, 16'h0003);
        wreg(8'h21, 16'h0030);
        wreg(8'h00, 16'h0021);
        step(2);
        cur(8'h08, 4'h3, 24'h00_0014);
        rreg(vic_pkg::CUR_ADDR, 16'h8308);
        cpri <= 4'h3;
        step(2);
        chk("request", 0, req);
        wreg(8'h21, 16'h0050);
        step(2);
        cur(8'h0D, 4'h5, 24'h00_001E);
        serve(8'h0D, 24'h00_001E);
        wreg(8'h00, 16'h0000);
        wreg(8'h10, 16'h0000);
        $display("test order done");
    endtask
    task t_hw;
        wreg(8'h1E, 16'h2000);
        wreg(8'h5B, 16'h0070);
        @(posedge clk);
        irq[237] <= 1'b1;
        @(posedge clk);
        irq[237] <= 1'b0;
        step(2);
        cur(8'hF5, 4'h7, 24'h00_01EE);
        rreg(8'h0E, 16'h2000);
        wreg(8'h0E, 16'h0000);
        step(2);
        chk("request", 0, req);
        $display("test hardware done");
    endtask
    task t_trap;
        wreg(8'h10, 16'h0001);
        wreg(8'h20, 16'h0007);
        wreg(8'h00, 16'h0001);
        for (int k = 0; k < 8; k++) begin
            cpri <= k[0] ? 4'hF : 4'h0;
            slow <= k[0];
            @(posedge clk);
            trap[k] <= 1'b1;
            @(posedge clk);
            trap[k] <= 1'b0;
            step(2);
            cur(8'(k), 4'hF - 4'(k), 24'h00_0004 + 24'(2 * k));
            rreg(vic_pkg::TRAP_ADDR, 16'(1 << k));
            serve(8'(k), 24'h00_0004 + 24'(2 * k));
        end
        cpri <= 4'h0;
        step(2);
        cur(8'h08, 4'h7, 24'h00_0014);
        $display("test trap done");
    endtask
    task t_alt;
        logic [23:0] e;
        for (int c = 0; c < 3; c++) begin
            rst_dut(c != 1, (c == 2) ? 13'h0000 : 13'h0003);
            e = (c == 0) ? {1'b0, 13'h0002, 10'h000} + 24'h00_0014
                : 24'h00_0014;
            wreg(8'h10, 16'h0001);
            wreg(8'h20, 16'h0001);
            wreg(8'h00, 16'h0001);
            step(2);
            cur(8'h08, 4'h1, 24'h00_0014);
            wreg(vic_pkg::CTRL_ADDR, 16'h8000);
            step(2);
            cur(8'h08, 4'h1, e);
            serve(8'h08, e);
        end
        rreg(vic_pkg::CTRL_ADDR, 16'h8000);
        $display("test alternate done");
    endtask
    initial begin
        rst = 1'b1;
        {wr, rd, take, slow} = 4'h0;
        {addr, trap, wdata, cpri} = 36'h0_0000_0000;
        irq = '0;
        fuse = 1'b1;
        lim = 13'h0003;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        step(3);
        t_regs();
        t_order();
        t_hw();
        t_trap();
        t_alt();
        wrap_up();
    end
endmodule
